/* rtl/gpc_map.svh */
// register offsets, field positions, codes and reset values of the management block
`ifndef GPC_MAP_SVH
`define GPC_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define GPC_REG_CFG 5'h09
`define GPC_REG_STS 5'h0a
`define GPC_REG_IDX_CTRL 5'h0d
`define GPC_REG_IDX_DATA 5'h0e

// ----------------------------------------------------------------
// configuration field positions and reset values
// ----------------------------------------------------------------
`define GPC_CFG_TEST_HI 15
`define GPC_CFG_TEST_LO 13
`define GPC_CFG_MAN_EN 12
`define GPC_CFG_MAN_MASTER 11
`define GPC_CFG_PORT_MULTI 10
`define GPC_CFG_ADV_FULL 9
`define GPC_CFG_ADV_HALF 8
`define GPC_CFG_AUTO_TEST 7
`define GPC_CFG_RSVD_ZERO 7'h00
`define GPC_TEST_NORMAL 3'h0
`define GPC_ADV_FULL_RST 1'b1
`define GPC_ADV_HALF_RST 1'b1

// ----------------------------------------------------------------
// status and indirect control fields
// ----------------------------------------------------------------
`define GPC_STS_RSVD_ZERO 2'h0
`define GPC_IDLE_MAX 8'hff
`define GPC_IDLE_ONE 8'h01
`define GPC_IDX_FUNC_HI 15
`define GPC_IDX_FUNC_LO 14
`define GPC_IDX_SEL_HI 4
`define GPC_IDX_SEL_LO 0
`define GPC_IDX_RSVD_ZERO 9'h000
`define GPC_FUNC_ADDR 2'h0
`define GPC_FUNC_DATA 2'h1
`define GPC_FUNC_INC_RW 2'h2
`define GPC_FUNC_INC_WR 2'h3
`define GPC_TARGET_VENDOR 5'h1f
`define GPC_PTR_STEP 16'h0001

// ----------------------------------------------------------------
// management frame layout
// ----------------------------------------------------------------
`define GPC_PREAMBLE_LEN 6'h20
`define GPC_HDR_LAST 6'h0c
`define GPC_TA_LEN 6'h02
`define GPC_TA_DRIVE 6'h01
`define GPC_DATA_LEN 6'h10
`define GPC_DATA_LAST 6'h0f
`define GPC_OP_READ 2'h2
`define GPC_OP_WRITE 2'h1
`define GPC_HDR_ST 12
`define GPC_HDR_OP_HI 11
`define GPC_HDR_OP_LO 10
`define GPC_HDR_PHY_HI 9
`define GPC_HDR_PHY_LO 5
`define GPC_HDR_REG_HI 4
`define GPC_HDR_REG_LO 0

`endif

/* rtl/gpc_pkg.sv */
// types of the gigabit management register block
package gpc_pkg;

    // ----------------------------------------------------------------
    // frame states
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        GPC_PRE = 5'b00001,
        GPC_HDR = 5'b00010,
        GPC_TA = 5'b00100,
        GPC_WR = 5'b01000,
        GPC_RD = 5'b10000
    } gpc_state_e;

    // ----------------------------------------------------------------
    // whole state of the block
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] mdcSync;
        logic [2:0] mdioSync;
        logic mdcLvl;
        gpc_state_e state;
        logic [5:0] bitCnt;
        logic [15:0] shift;
        logic isRead;
        logic [4:0] regAddr;
        logic [15:0] rdShift;
        logic extRdPend;
        logic mdioOut;
        logic mdioOe;
        logic [2:0] testMode;
        logic manualRoleEn;
        logic manualRoleMaster;
        logic portMulti;
        logic advFull;
        logic advHalf;
        logic autoCableTest;
        logic cableTestStart;
        logic faultLatch;
        logic [7:0] idleCnt;
        logic [1:0] idxFunc;
        logic [4:0] idxTarget;
        logic [15:0] extPtr;
        logic [15:0] extAddr;
        logic [15:0] extWrData;
        logic extWr;
        logic extRd;
    } gpc_regs_s;

endpackage : gpc_pkg

/* rtl/gpc_mgmt_regs.sv */
// gigabit configuration, gigabit status and indirect access over the management pins
`include "gpc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module gpc_mgmt_regs (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // management pins
    input wire logic mdc,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe,
    input wire logic [4:0] phyAddr,
    // line side status
    input wire logic msFaultDetect,
    input wire logic msResolvedMaster,
    input wire logic localRxOk,
    input wire logic remoteRxOk,
    input wire logic partnerFullDuplex,
    input wire logic partnerHalfDuplex,
    input wire logic idleErrorPulse,
    input wire logic linkDown,
    // line side control
    output logic [2:0] testMode,
    output logic manualRoleEn,
    output logic manualRoleMaster,
    output logic portMulti,
    output logic advFull,
    output logic advHalf,
    output logic cableTestStart,
    // extended register space
    output logic [15:0] extAddr,
    output logic [15:0] extWrData,
    output logic extWr,
    output logic extRd,
    input wire logic [15:0] extRdData
);

    gpc_pkg::gpc_regs_s state_q;
    gpc_pkg::gpc_regs_s state_d;
    logic rise;
    logic fall;
    logic bitIn;
    logic [15:0] rdVal;
    logic cfgRdEv;
    logic stsRdEv;
    logic idxWrEv;
    logic idxRdEv;
    logic [15:0] wrWord;
    logic [12:0] hdr;

    function automatic logic [15:0] ptrNext(input logic [15:0] ptr, input logic step);
        ptrNext = step ? ptr + `GPC_PTR_STEP : ptr;
    endfunction : ptrNext

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.extWr = 1'b0;
        state_d.extRd = 1'b0;
        state_d.extRdPend = 1'b0;
        cfgRdEv = 1'b0;
        stsRdEv = 1'b0;
        idxWrEv = 1'b0;
        idxRdEv = 1'b0;
        // three-stage sampling; a level counts once the last two agree
        state_d.mdcSync = {state_q.mdcSync[1:0], mdc};
        state_d.mdioSync = {state_q.mdioSync[1:0], mdioIn};
        if (state_q.mdcSync[1] == state_q.mdcSync[2]) begin
            state_d.mdcLvl = state_q.mdcSync[2];
        end
        rise = state_d.mdcLvl & ~state_q.mdcLvl;
        fall = ~state_d.mdcLvl & state_q.mdcLvl;
        bitIn = state_q.mdioSync[2];
        hdr = {state_q.shift[11:0], bitIn};
        wrWord = {state_q.shift[14:0], bitIn};

        // readback mux, reserved bits forced low
        case (hdr[`GPC_HDR_REG_HI:`GPC_HDR_REG_LO])
            `GPC_REG_CFG: rdVal = {state_q.testMode, state_q.manualRoleEn,
                state_q.manualRoleMaster, state_q.portMulti, state_q.advFull,
                state_q.advHalf, state_q.autoCableTest, `GPC_CFG_RSVD_ZERO};
            `GPC_REG_STS: rdVal = {state_q.faultLatch, msResolvedMaster,
                localRxOk, remoteRxOk, partnerFullDuplex, partnerHalfDuplex,
                `GPC_STS_RSVD_ZERO, state_q.idleCnt};
            `GPC_REG_IDX_CTRL: rdVal = {state_q.idxFunc, `GPC_IDX_RSVD_ZERO,
                state_q.idxTarget};
            `GPC_REG_IDX_DATA: rdVal = (state_q.idxFunc == `GPC_FUNC_ADDR
                && state_q.idxTarget == `GPC_TARGET_VENDOR) ? state_q.extPtr : '0;
            default: rdVal = '0;
        endcase

        // a new detection beats the clearing read
        state_d.faultLatch = state_q.faultLatch | msFaultDetect;
        if (idleErrorPulse && state_q.idleCnt != `GPC_IDLE_MAX) begin
            state_d.idleCnt = state_q.idleCnt + `GPC_IDLE_ONE;
        end
        state_d.cableTestStart = linkDown & state_q.autoCableTest;
        if (state_q.extRdPend) begin
            state_d.rdShift = extRdData;
        end

        case (state_q.state)
            gpc_pkg::GPC_PRE: begin
                if (rise) begin
                    if (bitIn) begin
                        if (state_q.bitCnt != `GPC_PREAMBLE_LEN) begin
                            state_d.bitCnt = state_q.bitCnt + 6'h01;
                        end
                    end else begin
                        if (state_q.bitCnt == `GPC_PREAMBLE_LEN) begin
                            state_d.state = gpc_pkg::GPC_HDR;
                        end
                        state_d.bitCnt = '0;
                    end
                end
            end
            gpc_pkg::GPC_HDR: begin
                if (rise) begin
                    state_d.shift = wrWord;
                    state_d.bitCnt = state_q.bitCnt + 6'h01;
                    if (state_q.bitCnt == `GPC_HDR_LAST) begin
                        state_d.bitCnt = '0;
                        state_d.regAddr = hdr[`GPC_HDR_REG_HI:`GPC_HDR_REG_LO];
                        state_d.state = gpc_pkg::GPC_PRE;
                        if (hdr[`GPC_HDR_ST] && hdr[`GPC_HDR_PHY_HI:`GPC_HDR_PHY_LO] == phyAddr)
                        begin
                            if (hdr[`GPC_HDR_OP_HI:`GPC_HDR_OP_LO] == `GPC_OP_WRITE) begin
                                state_d.isRead = 1'b0;
                                state_d.state = gpc_pkg::GPC_TA;
                            end else if (hdr[`GPC_HDR_OP_HI:`GPC_HDR_OP_LO] == `GPC_OP_READ)
                            begin
                                state_d.isRead = 1'b1;
                                state_d.state = gpc_pkg::GPC_TA;
                                state_d.rdShift = rdVal;
                                cfgRdEv = (state_d.regAddr == `GPC_REG_CFG);
                                stsRdEv = (state_d.regAddr == `GPC_REG_STS);
                                idxRdEv = (state_d.regAddr == `GPC_REG_IDX_DATA)
                                    && state_q.idxTarget == `GPC_TARGET_VENDOR;
                            end
                        end
                    end
                end
            end
            gpc_pkg::GPC_TA: begin
                if (fall && state_q.isRead && state_q.bitCnt == `GPC_TA_DRIVE) begin
                    state_d.mdioOe = 1'b1;
                    state_d.mdioOut = 1'b0;
                end
                if (rise) begin
                    state_d.bitCnt = state_q.bitCnt + 6'h01;
                    if (state_d.bitCnt == `GPC_TA_LEN) begin
                        state_d.bitCnt = '0;
                        state_d.state = state_q.isRead ? gpc_pkg::GPC_RD : gpc_pkg::GPC_WR;
                    end
                end
            end
            gpc_pkg::GPC_WR: begin
                if (rise) begin
                    state_d.shift = wrWord;
                    state_d.bitCnt = state_q.bitCnt + 6'h01;
                    if (state_q.bitCnt == `GPC_DATA_LAST) begin
                        state_d.bitCnt = '0;
                        state_d.state = gpc_pkg::GPC_PRE;
                        case (state_q.regAddr)
                            `GPC_REG_CFG: begin
                                state_d.testMode = wrWord[`GPC_CFG_TEST_HI:`GPC_CFG_TEST_LO];
                                state_d.manualRoleEn = wrWord[`GPC_CFG_MAN_EN];
                                state_d.manualRoleMaster = wrWord[`GPC_CFG_MAN_MASTER];
                                state_d.portMulti = wrWord[`GPC_CFG_PORT_MULTI];
                                state_d.advFull = wrWord[`GPC_CFG_ADV_FULL];
                                state_d.advHalf = wrWord[`GPC_CFG_ADV_HALF];
                                state_d.autoCableTest = wrWord[`GPC_CFG_AUTO_TEST];
                            end
                            `GPC_REG_IDX_CTRL: begin
                                state_d.idxFunc = wrWord[`GPC_IDX_FUNC_HI:`GPC_IDX_FUNC_LO];
                                state_d.idxTarget = wrWord[`GPC_IDX_SEL_HI:`GPC_IDX_SEL_LO];
                            end
                            `GPC_REG_IDX_DATA: begin
                                idxWrEv = (state_q.idxTarget == `GPC_TARGET_VENDOR);
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            gpc_pkg::GPC_RD: begin
                if (fall) begin
                    if (state_q.bitCnt != `GPC_DATA_LEN) begin
                        state_d.mdioOut = state_q.rdShift[15];
                        state_d.rdShift = {state_q.rdShift[14:0], 1'b0};
                        state_d.bitCnt = state_q.bitCnt + 6'h01;
                    end else begin
                        state_d.mdioOe = 1'b0;
                        state_d.mdioOut = 1'b0;
                        state_d.bitCnt = '0;
                        state_d.state = gpc_pkg::GPC_PRE;
                    end
                end
            end
            default: begin
                state_d.state = gpc_pkg::GPC_PRE;
                state_d.bitCnt = '0;
                state_d.mdioOe = 1'b0;
            end
        endcase

        // read side effects; an event in the same cycle survives the clear
        if (stsRdEv) begin
            state_d.faultLatch = msFaultDetect;
            state_d.idleCnt = idleErrorPulse ? `GPC_IDLE_ONE : '0;
        end

        // extended space is reached only through the indirect pair
        if (idxWrEv) begin
            if (state_q.idxFunc == `GPC_FUNC_ADDR) begin
                state_d.extPtr = wrWord;
            end else begin
                state_d.extWr = 1'b1;
                state_d.extAddr = state_q.extPtr;
                state_d.extWrData = wrWord;
                state_d.extPtr = ptrNext(state_q.extPtr,
                    state_q.idxFunc != `GPC_FUNC_DATA);
            end
        end
        if (idxRdEv && state_q.idxFunc != `GPC_FUNC_ADDR) begin
            // far side answers while the strobe stands, long before the first data bit leaves
            state_d.extRd = 1'b1;
            state_d.extRdPend = 1'b1;
            state_d.extAddr = state_q.extPtr;
            state_d.extPtr = ptrNext(state_q.extPtr,
                state_q.idxFunc == `GPC_FUNC_INC_RW);
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= '0;
            state_q.state <= gpc_pkg::GPC_PRE;
            state_q.testMode <= `GPC_TEST_NORMAL;
            state_q.advFull <= `GPC_ADV_FULL_RST;
            state_q.advHalf <= `GPC_ADV_HALF_RST;
        end else begin
            state_q <= state_d;
        end
    end

    assign mdioOut = state_q.mdioOut;
    assign mdioOe = state_q.mdioOe;
    assign testMode = state_q.testMode;
    assign manualRoleEn = state_q.manualRoleEn;
    assign manualRoleMaster = state_q.manualRoleMaster;
    assign portMulti = state_q.portMulti;
    assign advFull = state_q.advFull;
    assign advHalf = state_q.advHalf;
    assign cableTestStart = state_q.cableTestStart;
    assign extAddr = state_q.extAddr;
    assign extWrData = state_q.extWrData;
    assign extWr = state_q.extWr;
    assign extRd = state_q.extRd;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_stsRead;
        stsRdEv;
    endsequence

    sequence s_dataWrite(logic [1:0] f);
        idxWrEv && state_q.idxFunc == f;
    endsequence

    property p_cfgZero;
        @(posedge ref_clk) disable iff (rst) cfgRdEv |=> state_q.rdShift[6:0] == 7'h00;
    endproperty
    a_cfgZero: assert property (p_cfgZero) else $error("config bits not zero");

    property p_faultSet;
        @(posedge ref_clk) disable iff (rst) msFaultDetect |=> state_q.faultLatch;
    endproperty
    a_faultSet: assert property (p_faultSet) else $error("fault not latched");

    property p_faultClr;
        @(posedge ref_clk) disable iff (rst)
            s_stsRead ##0 !msFaultDetect |=> !state_q.faultLatch;
    endproperty
    a_faultClr: assert property (p_faultClr) else $error("fault not cleared by read");

    property p_idleClr;
        @(posedge ref_clk) disable iff (rst)
            s_stsRead ##0 !idleErrorPulse |=> state_q.idleCnt == 8'h00;
    endproperty
    a_idleClr: assert property (p_idleClr) else $error("idle count not cleared");

    property p_autoTest;
        @(posedge ref_clk) disable iff (rst)
            linkDown && state_q.autoCableTest |=> cableTestStart ##1 !cableTestStart [*1];
    endproperty
    a_autoTest: assert property (p_autoTest) else $error("cable test not started");

    property p_ptrLoad;
        @(posedge ref_clk) disable iff (rst)
            s_dataWrite(`GPC_FUNC_ADDR) |=> state_q.extPtr == $past(wrWord) && !extWr;
    endproperty
    a_ptrLoad: assert property (p_ptrLoad) else $error("pointer not loaded");

    property p_ptrHold;
        @(posedge ref_clk) disable iff (rst)
            s_dataWrite(`GPC_FUNC_DATA) |=> extWr && $stable(state_q.extPtr);
    endproperty
    a_ptrHold: assert property (p_ptrHold) else $error("pointer moved on plain data");

    property p_ptrIncRw;
        @(posedge ref_clk) disable iff (rst)
            idxRdEv && state_q.idxFunc == `GPC_FUNC_INC_RW
            |=> extRd && state_q.extPtr == $past(state_q.extPtr) + 16'h0001;
    endproperty
    a_ptrIncRw: assert property (p_ptrIncRw) else $error("pointer not advanced");

    property p_ptrWrOnly;
        @(posedge ref_clk) disable iff (rst)
            idxRdEv && state_q.idxFunc == `GPC_FUNC_INC_WR |=> $stable(state_q.extPtr);
    endproperty
    a_ptrWrOnly: assert property (p_ptrWrOnly) else $error("pointer moved on read");

    property p_target;
        @(posedge ref_clk) disable iff (rst)
            state_q.idxTarget != `GPC_TARGET_VENDOR |-> !idxWrEv && !idxRdEv;
    endproperty
    a_target: assert property (p_target) else $error("foreign target served");

endmodule : gpc_mgmt_regs

`default_nettype wire

/* tb/gpc_host_model.sv */
// management host model that clocks frames onto the serial pins
`timescale 1ns/1ps
`default_nettype none
module gpc_host_model (
    // clock
    input wire logic ref_clk,
    // management pins
    output logic mdc,
    output logic hostOut,
    output logic hostOe,
    input wire logic mdioLine
);
    initial begin
        mdc = 1'b0;
        hostOut = 1'b1;
        hostOe = 1'b0;
    end
    // ----------------------------------------
    // one bit: 8 cycles low, 9 high
    // ----------------------------------------
    // data moves only while mdc is low, so the device's rising-edge sample is clean
    task automatic bit_t(input logic b, input logic drv, output logic s);
        @(posedge ref_clk);
        #1;
        mdc = 1'b0;
        hostOut = b;
        hostOe = drv;
        repeat (8) @(posedge ref_clk);
        #1;
        mdc = 1'b1;
        s = mdioLine;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask : bit_t
    // ----------------------------------------
    // whole frame, read or write
    // ----------------------------------------
    task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] q);
        logic [13:0] hdr;
        logic s;
        hdr = {2'b01, rd ? 2'b10 : 2'b01, phy, ra};
        repeat (32) bit_t(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) bit_t(hdr[i], 1'b1, s);
        // host lets go of the line for turnaround and data on reads
        bit_t(1'b1, !rd, s);
        bit_t(1'b0, !rd, s);
        for (int i = 15; i >= 0; i--) begin
            bit_t(wd[i], !rd, s);
            q[i] = s;
        end
        bit_t(1'b1, 1'b0, s);
    endtask : frame
endmodule : gpc_host_model
`default_nettype wire

/* tb/test_gpc_mgmt_regs.sv */
// self-checking bench for the gigabit management register block
`include "gpc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module test_gpc_mgmt_regs;
    logic ref_clk, rst, mdc, hostOut, hostOe, mdioLine, mdioOut, mdioOe;
    logic [4:0] lv;
    logic [2:0] ev;
    logic [2:0] testMode;
    logic manualRoleEn, manualRoleMaster, portMulti, advFull, advHalf, cableTestStart;
    logic [15:0] extAddr, extWrData, lastAddr, lastWr, q, v;
    logic [15:0] extRdData;
    logic [15:0] idleRd = 16'h0000;
    logic extWr, extRd;
    int err_total = 0;
    int n_checks = 0;
    int nWr = 0;
    int nCt = 0;
    // pull-up wins when nobody drives the line
    assign mdioLine = mdioOe ? mdioOut : (hostOe ? hostOut : 1'b1);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    gpc_host_model host (.ref_clk(ref_clk), .mdc(mdc), .hostOut(hostOut), .hostOe(hostOe),
        .mdioLine(mdioLine));
    gpc_mgmt_regs dut (.ref_clk(ref_clk), .rst(rst), .mdc(mdc), .mdioIn(mdioLine),
        .mdioOut(mdioOut), .mdioOe(mdioOe), .phyAddr(5'h05), .msFaultDetect(ev[0]),
        .msResolvedMaster(lv[4]), .localRxOk(lv[3]), .remoteRxOk(lv[2]),
        .partnerFullDuplex(lv[1]), .partnerHalfDuplex(lv[0]), .idleErrorPulse(ev[1]),
        .linkDown(ev[2]), .testMode(testMode), .manualRoleEn(manualRoleEn),
        .manualRoleMaster(manualRoleMaster), .portMulti(portMulti), .advFull(advFull),
        .advHalf(advHalf), .cableTestStart(cableTestStart), .extAddr(extAddr),
        .extWrData(extWrData), .extWr(extWr), .extRd(extRd), .extRdData(extRdData));
    // ----------------------------------------
    // extended space stand-in
    // ----------------------------------------
    // answers while the read strobe stands; toggles when idle so a stray sample never looks right
    assign extRdData = extRd ? (extAddr ^ 16'h5a5a) : idleRd;
    always @(posedge ref_clk) begin
        idleRd <= ~idleRd;
        if (extWr | extRd) lastAddr <= extAddr;
        if (extWr) lastWr <= extWrData;
        if (extWr) nWr <= nWr + 1;
        if (cableTestStart) nCt <= nCt + 1;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        host.frame(1'b0, 5'h05, ra, d, q);
    endtask : wr
    task automatic rdc(input logic [4:0] ra, input logic [15:0] e, input string nm);
        host.frame(1'b1, 5'h05, ra, 16'h0000, q);
        chk(nm, e, q);
    endtask : rdc
    task automatic pulse(input int k);
        @(posedge ref_clk);
        #1;
        ev[k] = 1'b1;
        @(posedge ref_clk);
        #1;
        ev[k] = 1'b0;
    endtask : pulse
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (95000) @(posedge ref_clk);
        err_total++;
        close_out();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        lv = 5'h00;
        ev = 3'h0;
        repeat (12) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        chk("ports", 16'h0003, {8'h00, testMode, manualRoleEn, manualRoleMaster, portMulti,
            advFull, advHalf});
        rdc(`GPC_REG_CFG, 16'h0300, "cfg");
        rdc(`GPC_REG_STS, 16'h0000, "sts");
        for (int k = 0; k < 8; k++) begin
            v = {k[2:0], k[0], k[1], k[2], ~k[0], ~k[1], k[0], 7'h7f};
            wr(`GPC_REG_CFG, v);
            rdc(`GPC_REG_CFG, {v[15:7], 7'h00}, "cfg");
            chk("ports", {8'h00, v[15:8]}, {8'h00, testMode, manualRoleEn, manualRoleMaster,
                portMulti, advFull, advHalf});
            pulse(2);
            repeat (2) @(posedge ref_clk);
            chk("cableTests", 16'((k + 1) / 2), 16'(nCt));
        end
        // wrong device address is not ours
        host.frame(1'b0, 5'h06, `GPC_REG_CFG, 16'h0000, q);
        rdc(`GPC_REG_CFG, {v[15:7], 7'h00}, "cfg");
        lv = 5'h1f;
        pulse(0);
        repeat (3) pulse(1);
        wr(`GPC_REG_STS, 16'hffff);
        rdc(`GPC_REG_STS, 16'hfc03, "sts");
        rdc(`GPC_REG_STS, 16'h7c00, "sts");
        lv = 5'h15;
        ev[0] = 1'b1;
        rdc(`GPC_REG_STS, 16'hd400, "sts");
        rdc(`GPC_REG_STS, 16'hd400, "sts");
        ev[0] = 1'b0;
        rdc(`GPC_REG_STS, 16'hd400, "sts");
        repeat (300) pulse(1);
        rdc(`GPC_REG_STS, 16'h54ff, "sts");
        wr(`GPC_REG_IDX_CTRL, 16'h001f);
        wr(`GPC_REG_IDX_DATA, 16'h0100);
        rdc(`GPC_REG_IDX_DATA, 16'h0100, "pointer");
        wr(`GPC_REG_IDX_CTRL, 16'h401f);
        wr(`GPC_REG_IDX_DATA, 16'haaaa);
        chk("extWr", 16'haaaa, lastWr);
        rdc(`GPC_REG_IDX_DATA, 16'h5b5a, "extData");
        wr(`GPC_REG_IDX_CTRL, 16'h801f);
        wr(`GPC_REG_IDX_DATA, 16'h1234);
        rdc(`GPC_REG_IDX_DATA, 16'h5b5b, "extData");
        wr(`GPC_REG_IDX_CTRL, 16'hc01f);
        rdc(`GPC_REG_IDX_DATA, 16'h5b58, "extData");
        rdc(`GPC_REG_IDX_DATA, 16'h5b58, "extData");
        wr(`GPC_REG_IDX_DATA, 16'h5678);
        chk("extAddr", 16'h0102, lastAddr);
        wr(`GPC_REG_IDX_CTRL, 16'h401e);
        wr(`GPC_REG_IDX_DATA, 16'hffff);
        rdc(`GPC_REG_IDX_DATA, 16'h0000, "extData");
        chk("extWrites", 16'h0003, 16'(nWr));
        wr(`GPC_REG_IDX_CTRL, 16'h001f);
        rdc(`GPC_REG_IDX_DATA, 16'h0103, "pointer");
        close_out();
    end
endmodule : test_gpc_mgmt_regs
`default_nettype wire
